// [hdl/acqsts_regs.vh]
// register map, field codes and timing constants of the acquisition status
// block; definitions only, included by the two design files
`ifndef ACQSTS_REGS_VH
`define ACQSTS_REGS_VH

`define ACQSTS_ADDR_W 6
`define ACQSTS_CTRL 6'h00
`define ACQSTS_EXPOSURE 6'h04
`define ACQSTS_READOUT 6'h08
`define ACQSTS_RATE_PERIOD 6'h0C
`define ACQSTS_FRAME_COUNT 6'h10
`define ACQSTS_LINE_SEL 6'h14
`define ACQSTS_LINE_SRC 6'h18
`define ACQSTS_STATUS 6'h1C
`define ACQSTS_AOI 6'h20

// control register bits
`define ACQSTS_CTRL_LEGACY 0
`define ACQSTS_CTRL_HW_START 1
`define ACQSTS_CTRL_RATE_EN 2
`define ACQSTS_CTRL_RESET 32'h0000_0002

// line source codes
`define ACQSTS_SRC_OFF 2'h0
`define ACQSTS_SRC_EXPOSURE 2'h1
`define ACQSTS_SRC_TRIG_READY 2'h2
`define ACQSTS_SRC_START_WAIT 2'h3

// cycles at 20 MHz per microsecond; exposure and readout settings are in cycles
`define ACQSTS_CLK_MHZ 20
`define ACQSTS_EXP_DELAY 16'h0004
`define ACQSTS_EXP_RESET 32'h0000_07D0
`define ACQSTS_RD_RESET 32'h0000_0FA0
`define ACQSTS_ROW_CYCLES 32'h0000_0010
`define ACQSTS_AOI_RESET 32'h0000_0040
`define ACQSTS_FRAMES_RESET 32'h0000_0003
`define ACQSTS_CNT_ONE 32'h0000_0001

`endif

// [hdl/acqsts_line_mux.v]
// one physical output line: source select register and registered driver
// assumes the select code arrives from the register file in the same clock
`timescale 1ns/10ps
`include "acqsts_regs.vh"

module acqsts_line_mux #(
  parameter [1:0] RESET_SRC = 2'h0
) (
  input wire clk, // camera clock
  input wire rst, // asynchronous reset, high
  input wire wr_en, // write strobe for this line's source
  input wire [1:0] wr_src, // source code to store
  input wire exp_sig, // exposure active
  input wire rdy_sig, // trigger ready
  input wire wait_sig, // acquisition start wait
  output reg [1:0] src, // stored source code
  output reg line_out // registered line level
);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      src <= RESET_SRC;
      line_out <= 1'b0;
    end else begin
      if (wr_en) begin
        src <= wr_src; // [R4]
      end
      case (src)
        `ACQSTS_SRC_EXPOSURE: line_out <= exp_sig;
        `ACQSTS_SRC_TRIG_READY: line_out <= rdy_sig;
        `ACQSTS_SRC_START_WAIT: line_out <= wait_sig; // [R5]
        default: line_out <= 1'b0;
      endcase
    end
  end

endmodule // acqsts_line_mux

// [hdl/acqsts_top.v]
// acquisition status outputs: exposure timing, trigger ready, start wait,
// overtrigger event and four routable output lines behind AXI4-Lite.
// assumes trigger inputs already synchronous to MCLK, one write and one
// read at most outstanding on the bus.
`timescale 1ns/10ps
`include "acqsts_regs.vh"

// Notes on behaviour
// R1: exposure active high during each exposure
// R2: exposure active lags exposure by fixed delay
// R3: line 1 carries exposure active after reset
// R4: select line, then write its source
// R5: start wait routable to lines 1 to 4
// R6: ready follows frame or start trigger
// R7: ready high when safe, low at start
// R8: no exposure overlap, end after readout
// R9: ready timing from exposure, AOI, readout
// R10: enabled rate limit sets ready rate
// R11: limit above maximum gives maximum rate
// R12: line 2 carries trigger ready after reset
// R13: source triggers right after ready rises
// R14: start wait high while awaiting start
// R15: start wait low when start accepted
// R16: early start discarded, overtrigger pulse
// R17: start wait only in standard mode
// R18: start wait only with hardware start
// R19: unsafe frame triggers are ignored
// R20: after frame count, await start again
// R21: edge-detect inputs, registered outputs
module acqsts_top (
  input wire MCLK, // camera clock, 20 MHz
  input wire RESET, // asynchronous reset, high
  input wire FRAME_TRIG, // frame start trigger level
  input wire EXTERNAL_ACQ_START_TRIGGER, // acquisition start trigger
  output reg EXPOSURE_ACTIVE_OUT, // delayed exposure level
  output reg TRIGGER_READY_OUT, // safe to trigger
  output reg ACQ_START_WAIT_OUT, // awaiting acquisition start
  output reg OVERTRIGGER, // one-cycle overtrigger event
  output wire [3:0] OUT_LINE, // physical output lines 1..4
  input wire [5:0] S_AXI_AWADDR, // write address
  input wire S_AXI_AWVALID, // write address valid
  output wire S_AXI_AWREADY, // write address ready
  input wire [31:0] S_AXI_WDATA, // write data
  input wire [3:0] S_AXI_WSTRB, // write strobes
  input wire S_AXI_WVALID, // write data valid
  output wire S_AXI_WREADY, // write data ready
  output reg [1:0] S_AXI_BRESP, // write response
  output reg S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire [5:0] S_AXI_ARADDR, // read address
  input wire S_AXI_ARVALID, // read address valid
  output wire S_AXI_ARREADY, // read address ready
  output reg [31:0] S_AXI_RDATA, // read data
  output reg [1:0] S_AXI_RRESP, // read response
  output reg S_AXI_RVALID, // read data valid
  input wire S_AXI_RREADY // read data ready
);

  localparam [2:0] ST_WAIT_START = 3'b001;
  localparam [2:0] ST_WAIT_FRAME = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  reg [31:0] ctrl;
  reg [31:0] exposure_cycles;
  reg [31:0] readout_cycles;
  reg [31:0] rate_period;
  reg [31:0] frame_count;
  reg [31:0] aoi_rows;
  reg [1:0] line_sel;
  reg [2:0] state;
  reg [31:0] frames_done;
  reg frame_prev;
  reg start_prev;
  reg exposing;
  reg [31:0] exp_cnt;
  reg reading;
  reg [31:0] rd_cnt;
  reg [31:0] since_start;
  reg [15:0] exp_pipe;
  reg overtrig_seen;
  reg aw_held;
  reg w_held;
  reg [5:0] aw_addr;
  reg [31:0] w_data;

  wire legacy = ctrl[`ACQSTS_CTRL_LEGACY];
  wire hw_start = ctrl[`ACQSTS_CTRL_HW_START];
  wire rate_en = ctrl[`ACQSTS_CTRL_RATE_EN];
  wire frame_edge = FRAME_TRIG & ~frame_prev; // [R21]
  wire start_edge = EXTERNAL_ACQ_START_TRIGGER & ~start_prev; // [R21]
  wire [3:0] line_src_wr;
  wire [1:0] src0;
  wire [1:0] src1;
  wire [1:0] src2;
  wire [1:0] src3;

  ////////////////////////////////////////////////////////////////////////////
  // safe-to-trigger calculation
  // readout time grows with AOI height; cycles = rows * per-row + base
  wire [31:0] readout_total = readout_cycles + aoi_rows * `ACQSTS_ROW_CYCLES;
  // exposure may start only once exposure is over and the new one would
  // end no earlier than the running readout
  wire rd_left_ok = ~reading || (rd_cnt <= exposure_cycles); // [R8] [R9]
  wire rate_ok = ~rate_en || (rate_period == 32'h0000_0000)
    || (since_start >= rate_period); // [R10] [R11]
  wire safe = ~exposing & rd_left_ok & rate_ok; // [R19]

  // which trigger the acquisition logic obeys depends on control mode
  wire trig_pending = legacy ? (state == ST_IDLE) : (state == ST_WAIT_FRAME);
  wire trig_edge = legacy ? start_edge : frame_edge; // [R6]
  wire take = trig_pending & safe & trig_edge; // [R19]

  ////////////////////////////////////////////////////////////////////////////
  // acquisition state machine
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state <= ST_WAIT_START;
      frames_done <= 32'h0000_0000;
      frame_prev <= 1'b0;
      start_prev <= 1'b0;
      overtrig_seen <= 1'b0;
    end else begin
      frame_prev <= FRAME_TRIG;
      start_prev <= EXTERNAL_ACQ_START_TRIGGER;
      overtrig_seen <= 1'b0;
      // legacy mode has no start wait and no frame count
      if (legacy) begin
        state <= ST_IDLE;
        frames_done <= 32'h0000_0000;
      end else begin
        case (state)
          ST_WAIT_START: begin
            // software-started acquisitions begin at once
            if (~hw_start || start_edge) begin
              state <= ST_WAIT_FRAME; // [R15]
              frames_done <= 32'h0000_0000;
            end
          end
          ST_WAIT_FRAME: begin
            if (start_edge) begin
              overtrig_seen <= 1'b1; // [R16]
            end
            if (take) begin
              if (frames_done + `ACQSTS_CNT_ONE >= frame_count) begin
                state <= ST_WAIT_START; // [R20]
              end
              frames_done <= frames_done + `ACQSTS_CNT_ONE;
            end
          end
          default: state <= ST_WAIT_START;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exposure and readout timers
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      exposing <= 1'b0;
      exp_cnt <= 32'h0000_0000;
      reading <= 1'b0;
      rd_cnt <= 32'h0000_0000;
      since_start <= 32'h0000_0000;
    end else begin
      // saturate so a long idle never wraps into a false rate hold
      if (since_start != 32'hFFFF_FFFF) begin
        since_start <= since_start + `ACQSTS_CNT_ONE;
      end
      if (take) begin
        exposing <= 1'b1; // [R1]
        exp_cnt <= exposure_cycles;
        since_start <= 32'h0000_0000;
      end else if (exposing) begin
        if (exp_cnt <= `ACQSTS_CNT_ONE) begin
          exposing <= 1'b0; // [R1]
          reading <= 1'b1;
          rd_cnt <= readout_total;
        end else begin
          exp_cnt <= exp_cnt - `ACQSTS_CNT_ONE;
        end
      end
      // a readout restarted this cycle must not also count down
      // the old one, or the old readout's clear or decrement would override the new one
      if (reading && !(exposing && exp_cnt <= `ACQSTS_CNT_ONE)) begin
        if (rd_cnt <= `ACQSTS_CNT_ONE) begin
          reading <= 1'b0;
        end else begin
          rd_cnt <= rd_cnt - `ACQSTS_CNT_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered status outputs
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      exp_pipe <= 16'h0000;
      EXPOSURE_ACTIVE_OUT <= 1'b0;
      TRIGGER_READY_OUT <= 1'b0;
      ACQ_START_WAIT_OUT <= 1'b0;
      OVERTRIGGER <= 1'b0;
    end else begin
      // fixed lag on both edges, as the output stage has in silicon
      exp_pipe <= {exp_pipe[14:0], exposing};
      EXPOSURE_ACTIVE_OUT <= |(exp_pipe & `ACQSTS_EXP_DELAY); // [R2]
      TRIGGER_READY_OUT <= trig_pending & safe & ~take; // [R7] [R13]
      ACQ_START_WAIT_OUT <= (state == ST_WAIT_START) & ~legacy
        & hw_start; // [R14] [R17] [R18]
      OVERTRIGGER <= overtrig_seen; // [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output line routing
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_line
      localparam [1:0] LINE_IDX = gi;
      assign line_src_wr[gi] = (line_sel == LINE_IDX);
    end
  endgenerate

  wire wr_fire = aw_held & w_held & ~S_AXI_BVALID;
  wire src_wr = wr_fire & (aw_addr == `ACQSTS_LINE_SRC);

  acqsts_line_mux #(.RESET_SRC(`ACQSTS_SRC_EXPOSURE)) u_line0 ( // [R3]
    .clk(MCLK), .rst(RESET), .wr_en(src_wr & line_src_wr[0]),
    .wr_src(w_data[1:0]), .exp_sig(EXPOSURE_ACTIVE_OUT),
    .rdy_sig(TRIGGER_READY_OUT), .wait_sig(ACQ_START_WAIT_OUT),
    .src(src0), .line_out(OUT_LINE[0]));
  acqsts_line_mux #(.RESET_SRC(`ACQSTS_SRC_TRIG_READY)) u_line1 ( // [R12]
    .clk(MCLK), .rst(RESET), .wr_en(src_wr & line_src_wr[1]),
    .wr_src(w_data[1:0]), .exp_sig(EXPOSURE_ACTIVE_OUT),
    .rdy_sig(TRIGGER_READY_OUT), .wait_sig(ACQ_START_WAIT_OUT),
    .src(src1), .line_out(OUT_LINE[1]));
  acqsts_line_mux #(.RESET_SRC(`ACQSTS_SRC_OFF)) u_line2 (
    .clk(MCLK), .rst(RESET), .wr_en(src_wr & line_src_wr[2]),
    .wr_src(w_data[1:0]), .exp_sig(EXPOSURE_ACTIVE_OUT),
    .rdy_sig(TRIGGER_READY_OUT), .wait_sig(ACQ_START_WAIT_OUT),
    .src(src2), .line_out(OUT_LINE[2]));
  acqsts_line_mux #(.RESET_SRC(`ACQSTS_SRC_OFF)) u_line3 (
    .clk(MCLK), .rst(RESET), .wr_en(src_wr & line_src_wr[3]),
    .wr_src(w_data[1:0]), .exp_sig(EXPOSURE_ACTIVE_OUT),
    .rdy_sig(TRIGGER_READY_OUT), .wait_sig(ACQ_START_WAIT_OUT),
    .src(src3), .line_out(OUT_LINE[3]));

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data latched independently
  assign S_AXI_AWREADY = ~aw_held;
  assign S_AXI_WREADY = ~w_held;
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  reg [1:0] sel_src;
  always @* begin
    case (line_sel)
      2'h0: sel_src = src0;
      2'h1: sel_src = src1;
      2'h2: sel_src = src2;
      default: sel_src = src3;
    endcase
  end

  // strobes are ignored: every field is written as a whole word
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'b00;
      ctrl <= `ACQSTS_CTRL_RESET;
      exposure_cycles <= `ACQSTS_EXP_RESET;
      readout_cycles <= `ACQSTS_RD_RESET;
      rate_period <= 32'h0000_0000;
      frame_count <= `ACQSTS_FRAMES_RESET;
      aoi_rows <= `ACQSTS_AOI_RESET;
      line_sel <= 2'h0;
    end else begin
      if (S_AXI_AWVALID && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && !w_held) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= 2'b00;
        case (aw_addr)
          `ACQSTS_CTRL: ctrl <= {29'h0, w_data[2:0]};
          `ACQSTS_EXPOSURE: exposure_cycles <= w_data;
          `ACQSTS_READOUT: readout_cycles <= w_data;
          `ACQSTS_RATE_PERIOD: rate_period <= w_data;
          `ACQSTS_FRAME_COUNT: frame_count <= w_data;
          `ACQSTS_AOI: aoi_rows <= w_data;
          `ACQSTS_LINE_SEL: line_sel <= w_data[1:0]; // [R4]
          `ACQSTS_LINE_SRC: ;
          default: S_AXI_BRESP <= 2'b10;
        endcase
      end
    end
  end

  // read address is decoded on the edge that takes it, so no
  // address register is needed on the read side
  always @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'b00;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP <= 2'b00;
      case (S_AXI_ARADDR)
        `ACQSTS_CTRL: S_AXI_RDATA <= ctrl;
        `ACQSTS_EXPOSURE: S_AXI_RDATA <= exposure_cycles;
        `ACQSTS_READOUT: S_AXI_RDATA <= readout_cycles;
        `ACQSTS_RATE_PERIOD: S_AXI_RDATA <= rate_period;
        `ACQSTS_FRAME_COUNT: S_AXI_RDATA <= frame_count;
        `ACQSTS_AOI: S_AXI_RDATA <= aoi_rows;
        `ACQSTS_LINE_SEL: S_AXI_RDATA <= {30'h0, line_sel};
        `ACQSTS_LINE_SRC: S_AXI_RDATA <= {30'h0, sel_src};
        `ACQSTS_STATUS: S_AXI_RDATA <= {26'h0, state, reading, exposing,
          TRIGGER_READY_OUT};
        default: begin
          S_AXI_RDATA <= 32'h0000_0000;
          S_AXI_RRESP <= 2'b10;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // acqsts_top

// [tb/acqsts_checker.sv]
// checker: timing relations between triggers, status outputs and bus
// assumes the bench exposure setting is at least 9 cycles
`timescale 1ns/10ps
module acqsts_checker (
  input wire MCLK, // clock
  input wire RESET, // reset, high
  input wire FRAME_TRIG, // frame trigger
  input wire EXTERNAL_ACQ_START_TRIGGER, // start trigger
  input wire EXPOSURE_ACTIVE_OUT, // exposure level
  input wire TRIGGER_READY_OUT, // ready level
  input wire ACQ_START_WAIT_OUT, // start wait level
  input wire OVERTRIGGER, // overtrigger pulse
  input wire S_AXI_BVALID, // write response valid
  input wire S_AXI_BREADY, // write response ready
  input wire S_AXI_RVALID, // read valid
  input wire S_AXI_RREADY, // read ready
  input wire [31:0] S_AXI_RDATA // read data
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////////
  sequence start_edge;
    $rose(EXTERNAL_ACQ_START_TRIGGER) && ACQ_START_WAIT_OUT;
  endsequence
  sequence frame_edge;
    $rose(FRAME_TRIG) && TRIGGER_READY_OUT;
  endsequence
  sequence exp_rise;
    $rose(EXPOSURE_ACTIVE_OUT);
  endsequence
  a_wait_drop_start: assert property (
    start_edge |-> ##[1:4] !ACQ_START_WAIT_OUT)
    else $error("start wait stayed high after start");
  a_ready_drop: assert property (
    frame_edge |-> ##[0:3] !TRIGGER_READY_OUT)
    else $error("trigger ready stayed high after trigger");
  a_over_pulse: assert property (OVERTRIGGER |=> !OVERTRIGGER)
    else $error("overtrigger longer than one cycle");
  a_over_cause: assert property (OVERTRIGGER |->
    !ACQ_START_WAIT_OUT && $past(EXTERNAL_ACQ_START_TRIGGER, 1))
    else $error("overtrigger without early start");
  a_exp_ready_low: assert property (exp_rise |-> !TRIGGER_READY_OUT)
    else $error("ready high at exposure start");
  a_exp_min_width: assert property (
    exp_rise |=> EXPOSURE_ACTIVE_OUT[*8])
    else $error("exposure active too short");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped early");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data not held");
endmodule // acqsts_checker

// [tb/acqsts_trig_src.sv]
// external trigger source: fires a frame trigger when ready rises
// assumes ready is registered on clk; trigger held three cycles
`timescale 1ns/10ps
module acqsts_trig_src (
  input wire clk, // camera clock
  input wire rst, // reset, high
  input wire en, // source active
  input wire ready, // trigger ready from camera
  output reg trig // frame trigger level
);
  reg last;
  reg [1:0] hold;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      last <= 1'b0;
      hold <= 2'h0;
      trig <= 1'b0;
    end else begin
      last <= ready;
      // only on a fresh rise, so unsafe overlap is never asked for
      if (en && ready && !last) begin
        trig <= 1'b1;
        hold <= 2'h2;
      end else if (hold != 2'h0) hold <= hold - 2'h1;
      else trig <= 1'b0;
    end
  end
endmodule // acqsts_trig_src

// [tb/acqsts_tb_top.sv]
// testbench: acquisitions, rate limit, routing, modes, bus errors
// assumes checker and trigger source models compiled before
`timescale 1ns/10ps
`include "acqsts_regs.vh"
module acqsts_tb_top;
  reg MCLK = 0, RESET = 1, ast = 0, pen = 0;
  reg [5:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, got;
  reg awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  reg [1:0] gresp, gbr;
  wire ftrig, exp, rdy, wt, ovr, awr, wrdy, bv, arr, rv;
  wire [3:0] ol;
  wire [1:0] brsp, rresp;
  wire [31:0] rdata;
  integer err_count = 0, comparisons = 0;
  integer ev, fc, ao, rdv, nexp, gap, novr, bad, l;
  acqsts_top dut_u (.MCLK(MCLK), .RESET(RESET), .FRAME_TRIG(ftrig),
    .EXTERNAL_ACQ_START_TRIGGER(ast), .EXPOSURE_ACTIVE_OUT(exp),
    .TRIGGER_READY_OUT(rdy), .ACQ_START_WAIT_OUT(wt), .OVERTRIGGER(ovr),
    .OUT_LINE(ol), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(brsp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
  acqsts_trig_src src_u (.clk(MCLK), .rst(RESET), .en(pen), .ready(rdy),
    .trig(ftrig));
  initial forever #25 MCLK = ~MCLK;
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons++;
      if (g !== e) begin
        err_count++;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task tmo(input integer n);
    if (n >= 200) begin
      err_count++;
      $display("Error bus expected answer seen none");
      complete_run;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge MCLK);
  endtask
  task wr(input [5:0] a, input [31:0] d);
    integer n;
    reg da, dw;
    begin
      awaddr <= a; wdata <= d; awv <= 1; wv <= 1;
      n = 0; da = 0; dw = 0;
      do begin
        @(negedge MCLK);
        da = da | (awr & awv); dw = dw | (wrdy & wv);
        @(posedge MCLK);
        if (da) awv <= 0;
        if (dw) wv <= 0;
        n++;
      end while (!(da && dw) && n < 200);
      tmo(n); n = 0;
      do begin @(negedge MCLK); n++; end while (!bv && n < 200);
      tmo(n);
      gbr = brsp;
      @(posedge MCLK) bry <= 1;
      @(posedge MCLK) bry <= 0;
    end
  endtask
  task rd(input [5:0] a);
    integer n;
    reg ta;
    begin
      araddr <= a; arv <= 1; n = 0;
      do begin
        @(negedge MCLK); ta = arr; @(posedge MCLK); n++;
      end while (!ta && n < 200);
      arv <= 0; tmo(n); n = 0;
      do begin @(negedge MCLK); n++; end while (!rv && n < 200);
      tmo(n);
      @(posedge MCLK) rry <= 1;
      @(negedge MCLK) got = rdata;
      gresp = rresp;
      @(posedge MCLK) rry <= 0;
    end
  endtask
  // start pulse at 2, early start at 40; counts rises, gap, events
  task run(output integer ne, output integer g, output integer no,
           output integer bd);
    integer i, t0;
    reg pe, pr, ce;
    begin
      ne = 0; g = 0; no = 0; bd = 0; pe = 0; pr = 0; t0 = 0;
      for (i = 0; i < 3000; i++) begin
        @(negedge MCLK);
        ce = exp;
        if (ce && !pe) begin
          ne++;
          if (ne == 1) t0 = i;
          if (ne == 2) g = i - t0;
        end
        if (ovr === 1'b1) no++;
        if (ol[0] !== pe || ol[1] !== pr) bd++;
        pe = ce; pr = rdy;
        @(posedge MCLK);
        if (i == 2 || i == 40) ast <= 1;
        if (i == 5 || i == 43) ast <= 0;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ev = $urandom(30201);
    ev = 20 + $urandom % 16; fc = 2 + $urandom % 3; ao = 1 + $urandom % 2;
    rdv = 40 + 16 * ao;
    cyc(2); RESET <= 0; cyc(2);
    chk("start_wait", 1, wt);
    rd(`ACQSTS_CTRL); chk("ctrl", `ACQSTS_CTRL_RESET, got);
    wr(`ACQSTS_LINE_SEL, 0); rd(`ACQSTS_LINE_SRC);
    chk("line1_src", 1, got);
    wr(`ACQSTS_LINE_SEL, 1); rd(`ACQSTS_LINE_SRC);
    chk("line2_src", 2, got);
    rd(6'h3C); chk("unmapped", 0, got); chk("unmapped_resp", 2, gresp);
    wr(6'h3C, 0); chk("unmapped_wr", 2, gbr);
    wr(`ACQSTS_EXPOSURE, ev); wr(`ACQSTS_READOUT, 40);
    wr(`ACQSTS_AOI, ao); wr(`ACQSTS_FRAME_COUNT, fc); pen <= 1;
    chk("write_resp", 0, gbr);
    run(nexp, gap, novr, bad);
    chk("frames", fc, nexp);
    chk("overtrigger", 1, novr);
    chk("default_lines", 0, bad);
    chk("gap", 1, gap > ev && gap >= rdv - ev && gap <= rdv + ev);
    chk("wait_again", 1, wt);
    rd(`ACQSTS_STATUS); chk("status", 32'h08, got);
    wr(`ACQSTS_RATE_PERIOD, 300); wr(`ACQSTS_CTRL, 6);
    run(nexp, gap, novr, bad);
    chk("rate_gap", 1, gap >= 300 && gap <= 310);
    wr(`ACQSTS_RATE_PERIOD, 1); run(nexp, gap, novr, bad);
    chk("max_rate_gap", 1, gap > ev && gap <= rdv + ev);
    for (l = 0; l < 4; l++) begin
      wr(`ACQSTS_LINE_SEL, l); wr(`ACQSTS_LINE_SRC, 3);
    end
    cyc(2); chk("wait_lines", 4'hF, ol);
    pen <= 0; wr(`ACQSTS_CTRL, 0); cyc(3);
    chk("hw_off_wait", 0, wt);
    chk("hw_off_lines", 0, ol);
    wr(`ACQSTS_CTRL, 3); cyc(3);
    chk("legacy_wait", 0, wt);
    chk("legacy_ready", 1, rdy);
    run(nexp, gap, novr, bad);
    chk("legacy_frames", 1, nexp);
    chk("legacy_over", 0, novr);
    complete_run;
  end
  initial begin
    #5000000;
    err_count++;
    $display("Error run expected end seen hang");
    complete_run;
  end
endmodule // acqsts_tb_top
bind acqsts_top acqsts_checker chk_u (.MCLK(MCLK), .RESET(RESET),
  .FRAME_TRIG(FRAME_TRIG),
  .EXTERNAL_ACQ_START_TRIGGER(EXTERNAL_ACQ_START_TRIGGER),
  .EXPOSURE_ACTIVE_OUT(EXPOSURE_ACTIVE_OUT),
  .TRIGGER_READY_OUT(TRIGGER_READY_OUT),
  .ACQ_START_WAIT_OUT(ACQ_START_WAIT_OUT), .OVERTRIGGER(OVERTRIGGER),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA));
